// ### design/ites_top.sv
// interrupt, trap and event system core
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ites_top (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire ites_pkg::ites_bus_t bus,
  output logic [ites_pkg::DATA_W-1:0] rdata,
  input wire logic [ites_pkg::DED_N-1:0] dedReq,
  input wire logic [ites_pkg::SHR_NODES*ites_pkg::SHR_PER-1:0] shrReq,
  input wire logic [ites_pkg::ERU_N-1:0] eruPin,
  input wire logic [ites_pkg::ESR_N-1:0] esrPin,
  input wire logic [ites_pkg::HWT_N-1:0] hwTrap,
  input wire logic swTrapValid,
  input wire logic [6:0] swTrapNum,
  input wire logic [3:0] cpuPrio,
  input wire logic vecAck,
  input wire logic trapDone,
  output ites_pkg::ites_cpu_t cpu
);
  import ites_pkg::*;

  typedef struct packed {
    ites_node_t [NODES-1:0] node;
    ites_chan_t [CHANS-1:0] chan;
    logic [SHR_NODES-1:0][1:0] srcSel;
    logic [ERU_N-1:0][1:0] etlCfg;
    logic [ERU_N-1:0][9:0] oguCfg;
    logic [ERU_N-1:0] etlStat;
    logic [TRAP_N-1:0] trap_flag_register;
    logic [TRAP_N-1:0] trapPend;
    logic [5:0] esrCfg;
    logic jumpCache;
    logic [ERU_N-1:0] eruA;
    logic [ERU_N-1:0] eruB;
    logic [ERU_N-1:0] eruP;
    logic [ESR_N-1:0] esrA;
    logic [ESR_N-1:0] esrB;
    logic [ESR_N-1:0] esrP;
    logic swPend;
    logic [6:0] swNum;
    ites_eng_t eng;
    ites_kind_t kind;
    logic [3:0] waitCnt;
    logic [6:0] selIdx;
    logic trapBusy;
    logic [3:0] trapBusyIdx;
    ites_cpu_t out;
    logic [DATA_W-1:0] rdata;
  } ites_state_t;

  ites_state_t st_reg;
  ites_state_t st_next;

  ////////////////////////////////////////////////////////////////////////
  // combinational next state
  always_comb begin
    logic [ERU_N-1:0] etlEvt;
    logic [ERU_N-1:0] oguOut;
    logic [ESR_N-1:0] esrRise;
    logic [TRAP_N-1:0] trapEvt;
    logic [NODES-1:0] hwSet;
    logic found;
    logic [3:0] bestP;
    logic [6:0] best;
    logic tFound;
    logic [3:0] tIdx;
    logic [2:0] ch;
    ites_chan_t c;
    st_next = st_reg;
    etlEvt = '0;
    oguOut = '0;
    esrRise = '0;
    trapEvt = '0;
    hwSet = '0;
    found = 1'b0;
    bestP = 4'h0;
    best = 7'h00;
    tFound = 1'b0;
    tIdx = 4'h0;
    ch = 3'h0;
    c = '0;

    // pin synchronisers
    st_next.eruA = eruPin;
    st_next.eruB = st_reg.eruA;
    st_next.eruP = st_reg.eruB;
    st_next.esrA = esrPin;
    st_next.esrB = st_reg.esrA;
    st_next.esrP = st_reg.esrB;

    // edge trigger logic and gating units
    for (int i = 0; i < ERU_N; i++) begin
      etlEvt[i] = (st_reg.eruB[i] & ~st_reg.eruP[i] & st_reg.etlCfg[i][0])
        | (~st_reg.eruB[i] & st_reg.eruP[i] & st_reg.etlCfg[i][1]);
    end
    for (int i = 0; i < ERU_N; i++) begin
      logic hit;
      logic match;
      hit = |(etlEvt & st_reg.oguCfg[i][3:0]);
      match = (st_reg.etlStat & st_reg.oguCfg[i][9:6])
        == st_reg.oguCfg[i][9:6];
      case (st_reg.oguCfg[i][5:4])
        OGU_PASS: oguOut[i] = hit;
        OGU_MATCH: oguOut[i] = hit & match;
        OGU_MISS: oguOut[i] = hit & ~match;
        default: oguOut[i] = 1'b0;
      endcase
    end

    // trap sources
    for (int i = 0; i < ESR_N; i++) begin
      esrRise[i] = st_reg.esrB[i] & ~st_reg.esrP[i];
    end
    trapEvt[HWT_N-1:0] = hwTrap;
    trapEvt[HWT_N] = |(esrRise & st_reg.esrCfg[2:0]);
    trapEvt[HWT_N+1] = |(esrRise & st_reg.esrCfg[5:3]);

    // node sources
    for (int i = 0; i < ERU_N; i++) begin
      hwSet[ERU_NODE0+i] = oguOut[i];
    end
    for (int i = 0; i < DED_N; i++) begin
      hwSet[DED_NODE0+i] = dedReq[i];
    end
    for (int i = 0; i < SHR_NODES; i++) begin
      hwSet[SHR_NODE0+i] = shrReq[i*SHR_PER+int'(st_reg.srcSel[i])];
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes
    if (bus.wr) begin
      if (bus.addr < 9'(NODES)) begin
        st_next.node[bus.addr[6:0]] = bus.wdata[9:0];
      end else if (bus.addr >= CHAN_BASE && bus.addr < CHAN_END) begin
        ch = bus.addr[4:2];
        if (bus.addr[1:0] == CH_SRC) begin
          st_next.chan[ch].src = bus.wdata[PTR_W-1:0];
        end else if (bus.addr[1:0] == CH_DST) begin
          st_next.chan[ch].dst = bus.wdata[PTR_W-1:0];
        end else if (bus.addr[1:0] == CH_CTL) begin
          st_next.chan[ch].cnt = bus.wdata[7:0];
          st_next.chan[ch].byteMode = bus.wdata[8];
          st_next.chan[ch].incSrc = bus.wdata[9];
          st_next.chan[ch].incDst = bus.wdata[10];
          st_next.chan[ch].cont = bus.wdata[11];
        end
      end else if (bus.addr >= SSEL_BASE && bus.addr < ETL_BASE) begin
        if (bus.addr[3] == 1'b0) begin
          st_next.srcSel[bus.addr[2:0]] = bus.wdata[1:0];
        end
      end else if (bus.addr >= ETL_BASE && bus.addr < OGU_BASE) begin
        st_next.etlCfg[bus.addr[1:0]] = bus.wdata[1:0];
      end else if (bus.addr >= OGU_BASE && bus.addr < ETLSTAT_ADDR) begin
        st_next.oguCfg[bus.addr[1:0]] = bus.wdata[9:0];
      end else if (bus.addr == ETLSTAT_ADDR) begin
        st_next.etlStat = st_reg.etlStat & ~bus.wdata[ERU_N-1:0];
      end else if (bus.addr == TFR_ADDR) begin
        st_next.trap_flag_register = st_reg.trap_flag_register & ~bus.wdata[TRAP_N-1:0];
      end else if (bus.addr == ESRCFG_ADDR) begin
        st_next.esrCfg = bus.wdata[5:0];
      end else if (bus.addr == SYSCTL_ADDR) begin
        st_next.jumpCache = bus.wdata[0];
      end
    end

    // register reads, data in the following cycle
    st_next.rdata = '0;
    if (bus.rd) begin
      if (bus.addr < 9'(NODES)) begin
        st_next.rdata = 32'(st_reg.node[bus.addr[6:0]]);
      end else if (bus.addr >= CHAN_BASE && bus.addr < CHAN_END) begin
        c = st_reg.chan[bus.addr[4:2]];
        if (bus.addr[1:0] == CH_SRC) begin
          st_next.rdata = 32'(c.src);
        end else if (bus.addr[1:0] == CH_DST) begin
          st_next.rdata = 32'(c.dst);
        end else if (bus.addr[1:0] == CH_CTL) begin
          st_next.rdata = 32'({c.cont, c.incDst, c.incSrc, c.byteMode, c.cnt});
        end
      end else if (bus.addr >= SSEL_BASE && bus.addr < ETL_BASE) begin
        if (bus.addr[3] == 1'b0) begin
          st_next.rdata = 32'(st_reg.srcSel[bus.addr[2:0]]);
        end
      end else if (bus.addr >= ETL_BASE && bus.addr < OGU_BASE) begin
        st_next.rdata = 32'(st_reg.etlCfg[bus.addr[1:0]]);
      end else if (bus.addr >= OGU_BASE && bus.addr < ETLSTAT_ADDR) begin
        st_next.rdata = 32'(st_reg.oguCfg[bus.addr[1:0]]);
      end else if (bus.addr == ETLSTAT_ADDR) begin
        st_next.rdata = 32'(st_reg.etlStat);
      end else if (bus.addr == TFR_ADDR) begin
        st_next.rdata = 32'(st_reg.trap_flag_register);
      end else if (bus.addr == ESRCFG_ADDR) begin
        st_next.rdata = 32'(st_reg.esrCfg);
      end else if (bus.addr == SYSCTL_ADDR) begin
        st_next.rdata = 32'(st_reg.jumpCache);
      end else if (bus.addr == ENGSTAT_ADDR) begin
        st_next.rdata = 32'({st_reg.trapBusyIdx, st_reg.trapBusy,
          st_reg.selIdx, st_reg.kind, st_reg.eng});
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // arbitration
    for (int i = 0; i < NODES; i++) begin
      if (st_reg.node[i].req && st_reg.node[i].en
          && (!found || st_reg.node[i].prio > bestP)) begin
        found = 1'b1;
        bestP = st_reg.node[i].prio;
        best = 7'(i);
      end
    end
    for (int i = TRAP_N - 1; i >= 0; i--) begin
      if (st_reg.trapPend[i]) begin
        tFound = 1'b1;
        tIdx = 4'(i);
      end
    end

    if (trapDone) begin
      st_next.trapBusy = 1'b0;
    end

    // service engine
    st_next.out.moveStrobe = 1'b0;
    case (st_reg.eng)
      ENG_IDLE: begin
        if (tFound && (!st_reg.trapBusy || tIdx < st_reg.trapBusyIdx)) begin
          st_next.trapPend[tIdx] = 1'b0;
          st_next.kind = KIND_TRAP;
          st_next.selIdx = 7'(tIdx);
          st_next.trapBusy = 1'b1;
          st_next.trapBusyIdx = tIdx;
          st_next.eng = ENG_WAIT;
        end else if (!st_reg.trapBusy && st_reg.swPend) begin
          st_next.swPend = 1'b0;
          st_next.kind = KIND_SW;
          st_next.eng = ENG_WAIT;
        end else if (!st_reg.trapBusy && found && bestP > cpuPrio) begin
          st_next.node[best].req = 1'b0;
          st_next.kind = KIND_NODE;
          st_next.selIdx = best;
          st_next.eng = ENG_WAIT;
        end
        st_next.waitCnt = st_reg.jumpCache ? LAT_JC_CNT : LAT_NOJC_CNT;
      end
      ENG_WAIT: begin
        st_next.waitCnt = st_reg.waitCnt - 4'h1;
        if (st_reg.waitCnt == 4'h0) begin
          c = st_reg.chan[st_reg.node[st_reg.selIdx].chan];
          ch = st_reg.node[st_reg.selIdx].chan;
          if (st_reg.kind == KIND_TRAP) begin
            st_next.out.vecReq = 1'b1;
            st_next.out.vecNum = TRAP_VEC_BASE + 8'(st_reg.selIdx);
            st_next.eng = ENG_VEC;
          end else if (st_reg.kind == KIND_SW) begin
            st_next.out.vecReq = 1'b1;
            st_next.out.vecNum = 8'(st_reg.swNum);
            st_next.eng = ENG_VEC;
          end else if (st_reg.node[st_reg.selIdx].route
              && (c.cont || c.cnt != 8'h00)) begin
            st_next.out.moveStrobe = 1'b1;
            st_next.out.moveSrc = c.src;
            st_next.out.moveDst = c.dst;
            st_next.out.moveByte = c.byteMode;
            if (c.incSrc) begin
              st_next.chan[ch].src = c.src + (c.byteMode ? 24'h1 : 24'h2);
            end
            if (c.incDst) begin
              st_next.chan[ch].dst = c.dst + (c.byteMode ? 24'h1 : 24'h2);
            end
            if (!c.cont) begin
              st_next.chan[ch].cnt = c.cnt - 8'h01;
            end
            st_next.eng = ENG_MOVE;
          end else begin
            st_next.out.vecReq = 1'b1;
            st_next.out.vecNum = NODE_VEC_BASE + 8'(st_reg.selIdx);
            st_next.eng = ENG_VEC;
          end
        end
      end
      ENG_MOVE: begin
        st_next.eng = ENG_IDLE;
      end
      ENG_VEC: begin
        if (vecAck) begin
          st_next.out.vecReq = 1'b0;
          st_next.eng = ENG_IDLE;
        end
      end
      default: st_next.eng = ENG_IDLE;
    endcase

    ////////////////////////////////////////////////////////////////////////
    // event sets, set wins over any clear
    st_next.etlStat = st_next.etlStat | etlEvt;
    st_next.trap_flag_register = st_next.trap_flag_register | trapEvt;
    st_next.trapPend = st_next.trapPend | trapEvt;
    for (int i = 0; i < NODES; i++) begin
      if (hwSet[i]) begin
        st_next.node[i].req = 1'b1;
      end
    end
    if (swTrapValid) begin
      st_next.swPend = 1'b1;
      st_next.swNum = swTrapNum;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign cpu = st_reg.out;
endmodule : ites_top
`default_nettype wire

// ### include/ites_pkg.sv
// shared constants and types of the interrupt, trap and event system
// Function
// - each node routes to vectored interrupt or to a data-move channel
// - vectored service redirects execution to the node's vector table entry
// - a data-move service takes exactly one CPU cycle
// - data move copies byte or word, then bumps source, destination or both
// - each data move decrements the channel counter unless continuous
// - counter at zero raises the node's vectored interrupt instead of a move
// - eight independent interrupt-triggered data-move channels
// - least latency is 7 clocks with jump cache, 11 without
// - 112 nodes, each with request flag, enable flag and priority field
// - most sources dedicated; shared nodes pick source by selection regs
// - router has four edge channels, routing matrix, four gating units
// - edge logic detects rising, falling or both edges per channel
// - gating unit passes or blocks events on pattern match or miss
// - hardware trap branches at once to its own vector location
// - each trap sets its own bit in the trap flag register; the software trap sets no bit here
// - trap preempts unless a higher-priority trap is in service
// - interrupts and data moves do not interrupt a trap service
// - three service request pins make two system trap requests
// - software trap instruction starts the vector of its trap number
// - software write of a request flag raises the node like hardware
package ites_pkg;
  localparam int NODES = 112;
  localparam int DED_N = 100;
  localparam int SHR_NODES = 8;
  localparam int SHR_PER = 4;
  localparam int CHANS = 8;
  localparam int ERU_N = 4;
  localparam int ESR_N = 3;
  localparam int HWT_N = 8;
  localparam int TRAP_N = 10;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int PTR_W = 24;
  localparam int CNT_W = 8;
  // node numbering
  localparam int ERU_NODE0 = 0;
  localparam int DED_NODE0 = 4;
  localparam int SHR_NODE0 = 104;
  // word addresses
  localparam logic [8:0] NODE_BASE = 9'h000;
  localparam logic [8:0] CHAN_BASE = 9'h080;
  localparam logic [8:0] CHAN_END = 9'h0A0;
  localparam logic [8:0] SSEL_BASE = 9'h0A0;
  localparam logic [8:0] ETL_BASE = 9'h0B0;
  localparam logic [8:0] OGU_BASE = 9'h0B4;
  localparam logic [8:0] ETLSTAT_ADDR = 9'h0B8;
  localparam logic [8:0] TFR_ADDR = 9'h0C0;
  localparam logic [8:0] ESRCFG_ADDR = 9'h0C1;
  localparam logic [8:0] SYSCTL_ADDR = 9'h0C2;
  localparam logic [8:0] ENGSTAT_ADDR = 9'h0C3;
  // channel register fields
  localparam logic [1:0] CH_SRC = 2'h0;
  localparam logic [1:0] CH_DST = 2'h1;
  localparam logic [1:0] CH_CTL = 2'h2;
  // gating modes
  localparam logic [1:0] OGU_BLOCK = 2'h0;
  localparam logic [1:0] OGU_PASS = 2'h1;
  localparam logic [1:0] OGU_MATCH = 2'h2;
  localparam logic [1:0] OGU_MISS = 2'h3;
  // vectors
  localparam logic [7:0] TRAP_VEC_BASE = 8'h00;
  localparam logic [7:0] NODE_VEC_BASE = 8'h10;
  // response latency in CPU clocks
  localparam int LAT_JC = 7;
  localparam int LAT_NOJC = 11;
  localparam logic [3:0] LAT_JC_CNT = 4'(LAT_JC - 1);
  localparam logic [3:0] LAT_NOJC_CNT = 4'(LAT_NOJC - 1);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ites_bus_t;

  typedef struct packed {
    logic [2:0] chan;
    logic route;
    logic req;
    logic en;
    logic [3:0] prio;
  } ites_node_t;

  typedef struct packed {
    logic [PTR_W-1:0] src;
    logic [PTR_W-1:0] dst;
    logic [CNT_W-1:0] cnt;
    logic byteMode;
    logic incSrc;
    logic incDst;
    logic cont;
  } ites_chan_t;

  typedef struct packed {
    logic vecReq;
    logic [7:0] vecNum;
    logic moveStrobe;
    logic [PTR_W-1:0] moveSrc;
    logic [PTR_W-1:0] moveDst;
    logic moveByte;
  } ites_cpu_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_WAIT = 2'b01,
    ENG_MOVE = 2'b10,
    ENG_VEC = 2'b11
  } ites_eng_t;

  typedef enum logic [1:0] {
    KIND_NODE = 2'b00,
    KIND_TRAP = 2'b01,
    KIND_SW = 2'b10
  } ites_kind_t;
endpackage : ites_pkg

// ### sim/ites_top_asserts.sv
// port assertions of the interrupt and trap core
`timescale 1ns/1ps
`default_nettype none
module ites_top_asserts (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire ites_pkg::ites_bus_t bus,
  input wire logic [ites_pkg::DATA_W-1:0] rdata,
  input wire logic vecAck,
  input wire ites_pkg::ites_cpu_t cpu
);
  import ites_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_strobe_single: assert property (cpu.moveStrobe |=> !cpu.moveStrobe)
    else $error("move strobe longer than one cycle");
  chk_move_spacing: assert property (
    cpu.moveStrobe |=> !cpu.moveStrobe [*6])
    else $error("next move too soon");
  chk_move_then_vec: assert property (
    cpu.moveStrobe |=> !cpu.vecReq [*6])
    else $error("vector too soon after move");
  chk_vec_holds: assert property (
    cpu.vecReq && !vecAck |=> cpu.vecReq && $stable(cpu.vecNum))
    else $error("vector dropped or changed before ack");
  chk_vec_release: assert property (
    cpu.vecReq && vecAck |=> !cpu.vecReq [*6])
    else $error("vector not released after ack");
  chk_one_service: assert property (!(cpu.vecReq && cpu.moveStrobe))
    else $error("vector and move at once");
  chk_rdata_idle: assert property (!bus.rd |=> rdata == '0)
    else $error("read data without read");
  chk_unmapped_zero: assert property (
    bus.rd && bus.addr > ENGSTAT_ADDR |=> rdata == '0)
    else $error("unmapped read not zero");
endmodule : ites_top_asserts
bind ites_top ites_top_asserts u_chk (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .bus(bus),
  .rdata(rdata),
  .vecAck(vecAck),
  .cpu(cpu)
);
`default_nettype wire

// ### sim/ites_cpu_model.sv
// behavioural cpu core acknowledging vectors after ackDelay, ignoring move slots
`timescale 1ns/1ps
`default_nettype none
module ites_cpu_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire ites_pkg::ites_cpu_t cpu,
  input wire logic [3:0] ackDelay,
  output logic vecAck,
  output logic [7:0] vecCnt
);
  import ites_pkg::*;
  logic [3:0] waitCnt;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      vecAck <= 1'b0;
      waitCnt <= 4'h0;
      vecCnt <= 8'h00;
    end else begin
      vecAck <= 1'b0;
      if (cpu.vecReq && !vecAck) begin
        waitCnt <= waitCnt + 4'h1;
        if (waitCnt == ackDelay) begin
          vecAck <= 1'b1;
          vecCnt <= vecCnt + 8'h01;
          waitCnt <= 4'h0;
        end
      end
    end
  end
endmodule : ites_cpu_model
`default_nettype wire

// ### sim/test_ites_top.sv
// testbench of the interrupt and trap core
`timescale 1ns/1ps
`default_nettype none
module test_ites_top;
  import ites_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n;
  ites_bus_t bus;
  logic [DATA_W-1:0] rdata;
  logic [DED_N-1:0] dedReq;
  logic [SHR_NODES*SHR_PER-1:0] shrReq;
  logic [ERU_N-1:0] eruPin;
  logic [ESR_N-1:0] esrPin;
  logic [HWT_N-1:0] hwTrap;
  logic swTrapValid, trapDone, vecAck;
  logic [6:0] swTrapNum;
  logic [3:0] cpuPrio;
  ites_cpu_t cpu;
  logic [7:0] vecCnt, c;
  int errors, total_checks, k;
  logic [7:0] oguT [6] = '{8'h11, 8'h11, 8'h11, 8'h01, 8'hA1, 8'hB1};
  logic [1:0] etlT [6] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
  logic [1:0] expT [6] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h0, 2'h2};
  always #20 sys_clk = ~sys_clk;
  ites_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus),
    .rdata(rdata), .dedReq(dedReq), .shrReq(shrReq), .eruPin(eruPin),
    .esrPin(esrPin), .hwTrap(hwTrap), .swTrapValid(swTrapValid),
    .swTrapNum(swTrapNum), .cpuPrio(cpuPrio), .vecAck(vecAck),
    .trapDone(trapDone), .cpu(cpu));
  ites_cpu_model partner (.sys_clk(sys_clk), .arst_n(arst_n), .cpu(cpu),
    .ackDelay(4'h3), .vecAck(vecAck), .vecCnt(vecCnt));
  ////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task rd(input logic [8:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd
  task poke(input int w, input int i);
    @(posedge sys_clk);
    case (w)
      0: dedReq[i] <= 1'b1;
      1: shrReq[i] <= 1'b1;
      2: hwTrap[i] <= 1'b1;
      3: swTrapValid <= 1'b1;
      default: trapDone <= 1'b1;
    endcase
    @(posedge sys_clk);
    {dedReq, shrReq, hwTrap, swTrapValid, trapDone} <= '0;
  endtask : poke
  task waitSvc(input logic mv, input int lat, input logic [31:0] exp);
    int n;
    for (n = 1; n < 60; n++) begin
      @(posedge sys_clk);
      #1;
      if ((mv ? cpu.moveStrobe : cpu.vecReq) === 1'b1) break;
    end
    check(32'((mv ? cpu.moveStrobe : cpu.vecReq) === 1'b1), 32'h1);
    if (lat > 0) check(32'(n), 32'(lat));
    check(mv ? 32'(cpu.moveSrc) : 32'(cpu.vecNum), exp);
    if (!mv) repeat (8) @(posedge sys_clk);
  endtask : waitSvc
  task stop_test;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  initial begin
    {bus, dedReq, shrReq, eruPin, esrPin, hwTrap} = '0;
    {swTrapValid, trapDone, swTrapNum, cpuPrio} = '0;
    arst_n = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(NODE_BASE + 9'h5, 32'h0);
    rd(9'h1FF, 32'h0);
    wr(NODE_BASE + 9'h5, 32'h3A);
    waitSvc(1'b0, 12, 32'h15);
    rd(NODE_BASE + 9'h5, 32'h1A);
    wr(SYSCTL_ADDR, 32'h1);
    poke(0, 1);
    waitSvc(1'b0, 8, 32'h15);
    wr(CHAN_BASE + 9'h8, 32'h1000);
    wr(CHAN_BASE + 9'h9, 32'h2000);
    wr(CHAN_BASE + 9'hA, 32'h602);
    wr(NODE_BASE + 9'h6, 32'h153);
    for (k = 0; k < 2; k++) begin
      poke(0, 2);
      waitSvc(1'b1, 8, 32'h1000 + 2 * k);
      check(32'(cpu.moveDst), 32'h2000 + 2 * k);
      check(32'(cpu.moveByte), 32'h0);
    end
    rd(CHAN_BASE + 9'h8, 32'h1004);
    rd(CHAN_BASE + 9'hA, 32'h600);
    poke(0, 2);
    waitSvc(1'b0, 8, 32'h16);
    wr(CHAN_BASE + 9'hC, 32'h10);
    wr(CHAN_BASE + 9'hE, 32'hB00);
    wr(NODE_BASE + 9'h7, 32'h1D1);
    poke(0, 3);
    waitSvc(1'b1, 8, 32'h10);
    check(32'(cpu.moveByte), 32'h1);
    rd(CHAN_BASE + 9'hC, 32'h11);
    rd(CHAN_BASE + 9'hE, 32'hB00);
    cpuPrio <= 4'h5;
    wr(NODE_BASE + 9'h8, 32'h32);
    wr(NODE_BASE + 9'h9, 32'h35);
    rd(NODE_BASE + 9'h8, 32'h32);
    cpuPrio <= 4'h2;
    waitSvc(1'b0, 0, 32'h19);
    rd(NODE_BASE + 9'h8, 32'h32);
    cpuPrio <= 4'h0;
    waitSvc(1'b0, 0, 32'h18);
    poke(2, 3);
    waitSvc(1'b0, 8, 32'h3);
    rd(TFR_ADDR, 32'h8);
    poke(0, 1);
    repeat (30) @(posedge sys_clk);
    check(32'(cpu.vecReq), 32'h0);
    poke(2, 1);
    waitSvc(1'b0, 8, 32'h1);
    poke(4, 0);
    waitSvc(1'b0, 0, 32'h15);
    wr(TFR_ADDR, 32'hA);
    rd(TFR_ADDR, 32'h0);
    swTrapNum <= 7'h2A;
    poke(3, 0);
    waitSvc(1'b0, 0, 32'h2A);
    poke(4, 0);
    wr(ESRCFG_ADDR, 32'h11);
    for (k = 0; k < 2; k++) begin
      esrPin[k] <= 1'b1;
      waitSvc(1'b0, 0, 32'h8 + k);
      esrPin <= '0;
      poke(4, 0);
    end
    rd(TFR_ADDR, 32'h300);
    wr(SSEL_BASE, 32'h2);
    wr(NODE_BASE + 9'h68, 32'h11);
    c = vecCnt;
    poke(1, 0);
    repeat (20) @(posedge sys_clk);
    check(32'(vecCnt), 32'(c));
    poke(1, 2);
    waitSvc(1'b0, 0, 32'h78);
    wr(NODE_BASE, 32'h11);
    for (k = 0; k < 6; k++) begin
      wr(ETL_BASE, 32'(etlT[k]));
      wr(OGU_BASE, 32'(oguT[k]));
      c = vecCnt;
      eruPin[0] <= 1'b1;
      repeat (30) @(posedge sys_clk);
      eruPin[0] <= 1'b0;
      repeat (30) @(posedge sys_clk);
      check(32'(vecCnt), 32'(c) + 32'(expT[k]));
    end
    rd(ETLSTAT_ADDR, 32'h1);
    stop_test();
  end
endmodule : test_ites_top
`default_nettype wire
